//--- pkg/gps_pkg.sv
// package for the gpio port with pin steering: map, fields, resets, routes
package gps_pkg;

	////////////////////////////////////////////////////////////////////////
	// widths
	localparam int REG_W  = 8;
	localparam int PIN_W  = 16;
	localparam int FN_N   = 9;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int SYNC_N = 2;

	////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_DIR_A = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_DIR_B = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_PIN_A = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_PIN_B = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_LAT_A = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_LAT_B = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_ANA_A = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_ANA_B = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_WPU_B = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_APS0  = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_APS1  = 8'h28;

	////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [REG_W-1:0] DIR_RST = 8'hFF;
	localparam logic [REG_W-1:0] LAT_RST = 8'h00;
	localparam logic [REG_W-1:0] ANA_RST = 8'h00;
	localparam logic [REG_W-1:0] WPU_RST = 8'h00;
	localparam logic [REG_W-1:0] APS_RST = 8'h00;
	localparam logic [REG_W-1:0] APS1_MASK = 8'h01;
	localparam int TXCK_BIT = 0;

	////////////////////////////////////////////////////////////////////////
	// steerable functions, index = bit in {select1[0], select0[7:0]}
	localparam int FN_CAPCOMP1 = 0;
	localparam int FN_PWM1_C   = 1;
	localparam int FN_PWM1_D   = 2;
	localparam int FN_CAPCOMP2 = 3;
	localparam int FN_PWM2_B   = 4;
	localparam int FN_SS_ONE   = 5;
	localparam int FN_SDO_ONE  = 6;
	localparam int FN_RXDT     = 7;
	localparam int FN_TXCK     = 8;

	// pin index: port A pin n is n, port B pin n is 8+n
	localparam logic [FN_N-1:0][3:0] FN_PIN_DEF =
		{4'hA, 4'h9, 4'hA, 4'hD, 4'hF, 4'hE, 4'hF, 4'hE, 4'hB};
	localparam logic [FN_N-1:0][3:0] FN_PIN_ALT =
		{4'hD, 4'hA, 4'h6, 4'h5, 4'h6, 4'h7, 4'h6, 4'h7, 4'h8};

	////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic [FN_N-1:0] en;
		logic [FN_N-1:0] out;
		logic [FN_N-1:0] oe;
	} gps_periph_t;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} gps_apb_req_t;

endpackage : gps_pkg

//--- core/gps_sync.sv
// two-stage synchroniser for pad inputs
`timescale 1ns/1ps
module gps_sync #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             reset,
	// data
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	// first stage feeds only the second stage
	always_comb
	begin
		meta_d = asyncIn;
		sync_d = meta_q;
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign syncOut = sync_q;

endmodule : gps_sync

//--- core/gps_port.sv
// gpio ports A and B with alternate pin steering, apb register slave
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
// Functional notes
// - enabled peripheral takes over its pin from the gpio bit
// - each port has direction, pin-value and output latch registers
// - writing the pin-value register updates the output latch
// - latch read returns latch; pin-value read returns sampled pins
// - analog-select bits disable the digital input of the pin
// - analog-select registers exist on both ports; weak pull-up register on port B only
// - direction one is input, zero drives the pin from its latch
// - select registers route peripheral signals to one of two pins
// - nine steerable functions, including transmit/clock
// - changing a route never alters a direction register
// - overrides follow the function; unselected pin stays ordinary
// - select 0: eight rw bits, reset zero, receive at bit 7
// - receive route: port B pin 1 when clear, pin 2 when set
// - serial out route: port B pin 2 clear, port A pin 6 set
// - slave select route: port B pin 5 clear, port A pin 5 set
// - select 1 bit 0 routes transmit/clock; other bits read zero
module gps_port (
	// clock and reset
	input  wire logic                         ref_clk,
	input  wire logic                         reset,
	// apb slave
	input  wire gps_pkg::gps_apb_req_t        apbReq,
	output logic      [gps_pkg::DATA_W-1:0]   prdata,
	output logic                              pready,
	output logic                              pslverr,
	// pads
	input  wire logic [gps_pkg::PIN_W-1:0]    pinIn,
	output logic      [gps_pkg::PIN_W-1:0]    pinOut,
	output logic      [gps_pkg::PIN_W-1:0]    pinOe,
	output logic      [gps_pkg::PIN_W-1:0]    pullupOn,
	output logic      [gps_pkg::PIN_W-1:0]    analogOn,
	// peripherals
	input  wire gps_pkg::gps_periph_t         periph,
	output logic      [gps_pkg::FN_N-1:0]     periphIn
);
	import gps_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// register state
	logic [REG_W-1:0] dirA_q, dirA_d, dirB_q, dirB_d;
	logic [REG_W-1:0] latA_q, latA_d, latB_q, latB_d;
	logic [REG_W-1:0] anaA_q, anaA_d, anaB_q, anaB_d;
	logic [REG_W-1:0] wpuB_q, wpuB_d;
	logic [REG_W-1:0] aps0_q, aps0_d, aps1_q, aps1_d;
	logic [DATA_W-1:0] prdata_q, prdata_d;
	logic              pready_q, pready_d;
	logic              pslverr_q, pslverr_d;
	logic [PIN_W-1:0]  pinOut_q, pinOut_d;
	logic [PIN_W-1:0]  pinOe_q, pinOe_d;
	logic [PIN_W-1:0]  pullup_q, pullup_d;
	logic [PIN_W-1:0]  analog_q, analog_d;
	logic [FN_N-1:0]   pIn_q, pIn_d;

	logic [PIN_W-1:0]  pinSync;
	logic [PIN_W-1:0]  digIn;
	logic [FN_N-1:0]   routeSel;
	logic              access;
	logic              commit;
	logic              wrDone;
	logic              mapped;
	logic [REG_W-1:0]  rdByte;
	logic [REG_W-1:0]  wrByte;

	////////////////////////////////////////////////////////////////////////
	// pad input sampling
	gps_sync #(
		.WIDTH (PIN_W)
	) u_sync (
		.ref_clk (ref_clk),
		.reset   (reset),
		.asyncIn (pinIn),
		.syncOut (pinSync)
	);

	// disabled buffer reads low, saves toggling in analog mode
	assign digIn = pinSync & ~{anaB_q, anaA_q};

	////////////////////////////////////////////////////////////////////////
	// apb decode; answer one cycle into the access phase
	assign access = apbReq.psel & apbReq.penable;
	assign commit = access & pready_q;
	assign wrDone = commit & apbReq.pwrite;
	assign wrByte = apbReq.pwdata[REG_W-1:0];

	always_comb
	begin
		mapped = 1'b1;
		rdByte = '0;
		unique case (apbReq.paddr)
			OFS_DIR_A: rdByte = dirA_q;
			OFS_DIR_B: rdByte = dirB_q;
			OFS_PIN_A: rdByte = digIn[REG_W-1:0];
			OFS_PIN_B: rdByte = digIn[PIN_W-1:REG_W];
			OFS_LAT_A: rdByte = latA_q;
			OFS_LAT_B: rdByte = latB_q;
			OFS_ANA_A: rdByte = anaA_q;
			OFS_ANA_B: rdByte = anaB_q;
			OFS_WPU_B: rdByte = wpuB_q;
			OFS_APS0:  rdByte = aps0_q;
			OFS_APS1:  rdByte = aps1_q & APS1_MASK;
			default:   mapped = 1'b0;
		endcase
	end

	always_comb
	begin
		pready_d  = access & ~pready_q;
		pslverr_d = access & ~pready_q & ~mapped;
		prdata_d  = prdata_q;
		if (access & ~pready_q)
		begin
			prdata_d = '0;
			if (~apbReq.pwrite)
				prdata_d[REG_W-1:0] = rdByte;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register writes, taken on the completing edge only
	always_comb
	begin
		dirA_d = dirA_q;
		dirB_d = dirB_q;
		latA_d = latA_q;
		latB_d = latB_q;
		anaA_d = anaA_q;
		anaB_d = anaB_q;
		wpuB_d = wpuB_q;
		aps0_d = aps0_q;
		aps1_d = aps1_q;
		if (wrDone)
		begin
			unique case (apbReq.paddr)
				OFS_DIR_A: dirA_d = wrByte;
				OFS_DIR_B: dirB_d = wrByte;
				OFS_PIN_A, OFS_LAT_A: latA_d = wrByte;
				OFS_PIN_B, OFS_LAT_B: latB_d = wrByte;
				OFS_ANA_A: anaA_d = wrByte;
				OFS_ANA_B: anaB_d = wrByte;
				OFS_WPU_B: wpuB_d = wrByte;
				OFS_APS0:  aps0_d = wrByte;
				OFS_APS1:  aps1_d = wrByte & APS1_MASK;
				default:   ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin steering and pad drive
	assign routeSel = {aps1_q[TXCK_BIT], aps0_q};

	always_comb
	begin
		logic [3:0] pinIdx;
		pinIdx   = '0;
		pinOut_d = {latB_q, latA_q};
		pinOe_d  = ~{dirB_q, dirA_q};
		pIn_d    = '0;
		// later functions win when two claim one pin
		for (int f = 0; f < FN_N; f++)
		begin
			pinIdx = routeSel[f] ? FN_PIN_ALT[f] : FN_PIN_DEF[f];
			if (periph.en[f])
			begin
				pinOut_d[pinIdx] = periph.out[f];
				pinOe_d[pinIdx]  = periph.oe[f];
			end
			pIn_d[f] = digIn[pinIdx];
		end
		// pull-ups only act while the pin is an input
		pullup_d = {wpuB_q & dirB_q, {REG_W{1'b0}}};
		analog_d = {anaB_q, anaA_q};
	end

	////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			dirA_q    <= DIR_RST;
			dirB_q    <= DIR_RST;
			latA_q    <= LAT_RST;
			latB_q    <= LAT_RST;
			anaA_q    <= ANA_RST;
			anaB_q    <= ANA_RST;
			wpuB_q    <= WPU_RST;
			aps0_q    <= APS_RST;
			aps1_q    <= APS_RST;
			prdata_q  <= '0;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			pinOut_q  <= '0;
			pinOe_q   <= '0;
			pullup_q  <= '0;
			analog_q  <= '0;
			pIn_q     <= '0;
		end
		else
		begin
			dirA_q    <= dirA_d;
			dirB_q    <= dirB_d;
			latA_q    <= latA_d;
			latB_q    <= latB_d;
			anaA_q    <= anaA_d;
			anaB_q    <= anaB_d;
			wpuB_q    <= wpuB_d;
			aps0_q    <= aps0_d;
			aps1_q    <= aps1_d;
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
			pinOut_q  <= pinOut_d;
			pinOe_q   <= pinOe_d;
			pullup_q  <= pullup_d;
			analog_q  <= analog_d;
			pIn_q     <= pIn_d;
		end
	end

	assign prdata   = prdata_q;
	assign pready   = pready_q;
	assign pslverr  = pslverr_q;
	assign pinOut   = pinOut_q;
	assign pinOe    = pinOe_q;
	assign pullupOn = pullup_q;
	assign analogOn = analog_q;
	assign periphIn = pIn_q;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	logic firstAcc;
	assign firstAcc = access & ~pready_q;

	AST_LAT_WRITE: assert property (
		wrDone && apbReq.paddr == OFS_PIN_A |=> latA_q == $past(wrByte))
		else $error("pin-value write did not reach latch");
	AST_LAT_READ: assert property (
		firstAcc && !apbReq.pwrite && apbReq.paddr == OFS_LAT_A
		|=> pready && prdata[REG_W-1:0] == latA_q)
		else $error("latch read wrong");
	AST_PIN_READ: assert property (
		firstAcc && !apbReq.pwrite && apbReq.paddr == OFS_PIN_A
		|=> prdata[REG_W-1:0] == $past(pinSync[REG_W-1:0] & ~anaA_q))
		else $error("pin read wrong");
	AST_ANA_ZERO: assert property (
		firstAcc && !apbReq.pwrite && apbReq.paddr == OFS_PIN_B
		|=> (prdata[REG_W-1:0] & $past(anaB_q)) == '0)
		else $error("analog pin read not zero");
	AST_DIR_OUT: assert property (
		!dirA_q[0] |=> pinOe[0] && pinOut[0] == $past(latA_q[0]))
		else $error("output pin not driven from latch");
	AST_DIR_IN: assert property (
		dirA_q[0] |=> !pinOe[0])
		else $error("input pin driven");
	AST_APS_NO_DIR: assert property (
		wrDone && apbReq.paddr == OFS_APS0
		|=> $stable(dirA_q) && $stable(dirB_q))
		else $error("route write changed direction");
	AST_ROUTE_SDO: assert property (
		periph.en[FN_SDO_ONE] && aps0_q[FN_SDO_ONE]
		&& !periph.en[FN_PWM1_D] && !periph.en[FN_PWM2_B]
		|=> pinOut[6] == $past(periph.out[FN_SDO_ONE])
		&& pinOe[6] == $past(periph.oe[FN_SDO_ONE]))
		else $error("serial out not on alternate pin");
	AST_ROUTE_RX: assert property (
		1'b1 |=> periphIn[FN_RXDT] ==
		$past(aps0_q[FN_RXDT] ? digIn[10] : digIn[9]))
		else $error("receive input from wrong pin");
	AST_ROUTE_SS: assert property (
		periph.en[FN_SS_ONE] && !aps0_q[FN_SS_ONE]
		&& !(periph.en[FN_TXCK] && aps1_q[TXCK_BIT])
		|=> pinOe[13] == $past(periph.oe[FN_SS_ONE]))
		else $error("slave select not on default pin");
	AST_APS1_ZERO: assert property (
		firstAcc && !apbReq.pwrite && apbReq.paddr == OFS_APS1
		|=> prdata[REG_W-1:1] == '0)
		else $error("select 1 upper bits not zero");
	AST_READY: assert property (
		firstAcc |=> pready ##1 !pready)
		else $error("ready not one cycle");
	AST_PULLUP_A: assert property (
		pullupOn[REG_W-1:0] == '0)
		else $error("port A pull-up active");
	AST_RX_ANALOG: assert property (
		anaB_q[FN_PIN_DEF[FN_RXDT] - REG_W] && !aps0_q[FN_RXDT]
		|=> !periphIn[FN_RXDT])
		else $error("analog receive pin seen by peripheral");
	AST_CCP1_TAKE: assert property (
		periph.en[FN_CAPCOMP1] && !aps0_q[FN_CAPCOMP1]
		|=> pinOut[FN_PIN_DEF[FN_CAPCOMP1]] ==
		$past(periph.out[FN_CAPCOMP1])
		&& pinOe[FN_PIN_DEF[FN_CAPCOMP1]] ==
		$past(periph.oe[FN_CAPCOMP1]))
		else $error("enabled peripheral did not take its pin");

	COV_LAT_WR: cover property (wrDone && apbReq.paddr == OFS_LAT_B);
	COV_PIN_RD: cover property (commit && apbReq.paddr == OFS_PIN_A);
	COV_SDO_ALT: cover property (periph.en[FN_SDO_ONE] && aps0_q[6]);
	COV_ERR: cover property (pslverr);

endmodule : gps_port

//--- sim/gps_pads.sv
// pad-side model: external drivers, pull-ups and floating pins
`timescale 1ns/1ps
module gps_pads (
	// clock
	input  wire logic                      ref_clk,
	// from the port
	input  wire logic [gps_pkg::PIN_W-1:0] pinOut,
	input  wire logic [gps_pkg::PIN_W-1:0] pinOe,
	input  wire logic [gps_pkg::PIN_W-1:0] pullupOn,
	// external drivers
	input  wire logic [gps_pkg::PIN_W-1:0] extOn,
	input  wire logic [gps_pkg::PIN_W-1:0] extVal,
	// to the port
	output logic      [gps_pkg::PIN_W-1:0] pinIn
);
	import gps_pkg::*;
	logic [PIN_W-1:0] floatPat_q = 16'h5555;
	////////////////////////////////////////////////////////////////////////
	// undriven pins wander so a stale level never passes
	always_ff @(posedge ref_clk)
	begin
		floatPat_q <= ~floatPat_q;
	end
	assign pinIn = (pinOe & pinOut) | (~pinOe & extOn & extVal)
		| (~pinOe & ~extOn & (pullupOn | floatPat_q));
endmodule : gps_pads

//--- sim/gps_port_test.sv
// self-checking bench for the gpio port with pin steering
`timescale 1ns/1ps
module gps_port_test;
	import gps_pkg::*;
	logic              ref_clk = 1'b0;
	logic              reset = 1'b1;
	gps_apb_req_t      apbReq = '0;
	gps_periph_t       periph = '0;
	logic [DATA_W-1:0] prdata;
	logic              pready;
	logic              pslverr;
	logic [PIN_W-1:0]  pinIn, pinOut, pinOe, pullupOn, analogOn;
	logic [PIN_W-1:0]  extOn = 16'hFFFF;
	logic [PIN_W-1:0]  extVal = 16'h0000;
	logic [FN_N-1:0]   periphIn;
	logic [DATA_W-1:0] rd;
	logic              err;
	int                num_errors = 0;
	int                compares = 0;
	// own pin map per function, port B pin n is 8+n
	int                pinDef[FN_N] = '{11, 14, 15, 14, 15, 13, 10, 9, 10};
	int                pinAlt[FN_N] = '{8, 7, 6, 7, 6, 5, 6, 10, 13};

	always #2.5 ref_clk = ~ref_clk;

	gps_port uut (.ref_clk(ref_clk), .reset(reset), .apbReq(apbReq),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
		.pullupOn(pullupOn), .analogOn(analogOn), .periph(periph),
		.periphIn(periphIn));
	gps_pads pads (.ref_clk(ref_clk), .pinOut(pinOut), .pinOe(pinOe),
		.pullupOn(pullupOn), .extOn(extOn), .extVal(extVal),
		.pinIn(pinIn));

	////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test

	task automatic chk(input logic [DATA_W-1:0] seen,
		input logic [DATA_W-1:0] exp);
		compares++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// no fixed latency assumed: wait for pready under a bound
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d);
		int n;
		@(posedge ref_clk);
		apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
			pwdata: d};
		@(posedge ref_clk);
		apbReq.penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			num_errors++;
			stop_test();
		end
		else
		begin
			rd = prdata;
			err = pslverr;
			apbReq.psel <= 1'b0;
			apbReq.penable <= 1'b0;
		end
	endtask : apb

	task automatic look(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : look

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		for (int i = 0; i < 11; i++)
			if (i != 2 && i != 3)
			begin
				apb(1'b0, 8'(i * 4), '0);
				chk(rd, i < 2 ? 32'h000000FF : 32'h0);
			end
		chk(32'(pinOe), 32'h0);
		$display("test reset done");
	endtask : t_reset

	task automatic t_latch();
		apb(1'b1, OFS_LAT_A, 32'hA5);
		apb(1'b1, OFS_DIR_A, 32'h38);
		extVal <= 16'h0018;
		look(4);
		chk(32'(pinOe[7:0]), 32'hC7);
		chk(32'(pinOut[7:0] & pinOe[7:0]), 32'h85);
		apb(1'b0, OFS_LAT_A, '0);
		chk(rd, 32'hA5);
		apb(1'b0, OFS_PIN_A, '0);
		chk(rd, 32'h9D);
		apb(1'b1, OFS_PIN_B, 32'h3C);
		apb(1'b0, OFS_LAT_B, '0);
		chk(rd, 32'h3C);
		apb(1'b0, OFS_PIN_B, '0);
		chk(rd, 32'h0);
		$display("test latch done");
	endtask : t_latch

	task automatic t_analog();
		extVal <= 16'hFF18;
		apb(1'b1, OFS_ANA_A, 32'h0F);
		apb(1'b1, OFS_ANA_B, 32'h0F);
		look(1);
		chk(32'(analogOn), 32'h0F0F);
		chk(32'(periphIn[FN_RXDT]), 32'h0);
		apb(1'b0, OFS_PIN_A, '0);
		chk(rd, 32'h90);
		apb(1'b0, OFS_PIN_B, '0);
		chk(rd, 32'hF0);
		apb(1'b1, OFS_ANA_A, '0);
		apb(1'b1, OFS_ANA_B, '0);
		$display("test analog done");
	endtask : t_analog

	task automatic t_steer();
		int sp;
		int op;
		apb(1'b1, OFS_DIR_A, 32'hFF);
		for (int f = 0; f < FN_N; f++)
			for (int s = 0; s < 2; s++)
			begin
				sp = s ? pinAlt[f] : pinDef[f];
				op = s ? pinDef[f] : pinAlt[f];
				@(posedge ref_clk);
				periph <= '{en: 9'(1 << f), out: 9'(1 << f), oe: 9'(1 << f)};
				extVal <= 16'(1 << sp);
				apb(1'b1, f == 8 ? OFS_APS1 : OFS_APS0, 32'(s << (f % 8)));
				look(2);
				chk(32'({pinOe[sp], pinOut[sp], pinOe[op]}), 32'h6);
				@(posedge ref_clk);
				periph.oe <= '0;
				look(5);
				chk(32'(periphIn[f]), 32'h1);
			end
		@(posedge ref_clk);
		periph <= '0;
		apb(1'b0, OFS_DIR_A, '0);
		chk(rd, 32'hFF);
		apb(1'b0, OFS_DIR_B, '0);
		chk(rd, 32'hFF);
		apb(1'b0, OFS_APS0, '0);
		chk(rd, 32'h80);
		apb(1'b1, OFS_APS1, 32'hFF);
		apb(1'b0, OFS_APS1, '0);
		chk(rd, 32'h01);
		$display("test steer done");
	endtask : t_steer

	task automatic t_pullup();
		@(posedge ref_clk);
		extOn <= 16'h00FF;
		apb(1'b1, OFS_WPU_B, 32'hFF);
		apb(1'b1, OFS_DIR_B, 32'hF0);
		look(4);
		chk(32'(pullupOn), 32'hF000);
		apb(1'b0, OFS_PIN_B, '0);
		chk(rd, 32'hFC);
		$display("test pullup done");
	endtask : t_pullup

	// refused accesses leave the registers alone
	task automatic t_unmapped();
		apb(1'b1, 8'h3C, 32'hFF);
		chk(32'(err), 32'h1);
		apb(1'b1, 8'h25, 32'hFF);
		chk(32'(err), 32'h1);
		apb(1'b0, 8'h3C, '0);
		chk({rd[30:0], err}, 32'h1);
		apb(1'b0, OFS_APS0, '0);
		chk(rd, 32'h80);
		$display("test unmapped done");
	endtask : t_unmapped

	initial
	begin
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		t_reset();
		t_latch();
		t_analog();
		t_steer();
		t_pullup();
		t_unmapped();
		stop_test();
	end
endmodule : gps_port_test
